/* core/sctr_regs.sv */
// Synth calibration test register bank with calibration timer and pump current step-down
module sctr_regs (
  input wire logic SYS_CLK, // 200 MHz clock
  input wire logic RESET_N, // Synchronous reset, active low
  input wire logic REG_WR, // Register write strobe
  input wire logic [5:0] REG_ADDR, // Register address
  input wire logic [15:0] REG_WDATA, // Write data
  output logic [15:0] REG_RDATA, // Read data
  input wire logic ENTER_RX, // Pulse: entering receive
  input wire logic ENTER_TX, // Pulse: entering transmit
  input wire logic TX_CAL_STROBE, // Pulse: transmit calibrate command
  input wire logic [4:0] CAL_ARRAY_IN, // Array value from calibration
  input wire logic [5:0] CAL_CURRENT_IN, // Current value from calibration
  input wire logic PD_UP, // Phase detector up pulse
  input wire logic PD_DOWN, // Phase detector down pulse
  input wire logic TUNING_TEST_IN, // Tuning node test input enabled
  output logic [4:0] MED_TO_HIGH_GAIN_STEP, // Gain step medium to high
  output logic [4:0] LOW_TO_MED_GAIN_STEP, // Gain step low to medium
  output logic PUMP_UP, // Pump up drive
  output logic PUMP_DOWN, // Pump down drive
  output logic TUNING_FROM_DAC, // Tuning node driven by DAC
  output sctr_pkg::sctr_synth_t SYNTH // Synth controls
);
  logic [15:0] gain_step_difference;
  logic [15:0] osc_array_calibration;
  logic [15:0] osc_calibration_setup;
  logic [15:0] osc_current_calibration;
  logic [15:0] pump_current_control;
  logic [4:0] osc_array_result;
  logic [5:0] osc_current_result;
  sctr_pkg::sctr_state_t state;
  logic [13:0] cal_count;
  logic [13:0] cal_len;
  logic [9:0] step_count;
  logic [9:0] step_len;
  logic [3:0] pump_current;
  logic cal_start;
  logic [3:0] pump_begin;
  logic [3:0] pump_end;
  logic step_due;
  logic [13:0] cal_age;

  // Register writes; reserved and read-only bits never stored
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      gain_step_difference <= sctr_pkg::RST_GAIN_STEP;
      osc_array_calibration <= sctr_pkg::RST_ARRAY_CAL;
      osc_calibration_setup <= sctr_pkg::RST_CAL_SETUP;
      osc_current_calibration <= sctr_pkg::RST_CURRENT_CAL;
      pump_current_control <= sctr_pkg::RST_PUMP_CTRL;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        sctr_pkg::ADDR_GAIN_STEP: gain_step_difference <= REG_WDATA & sctr_pkg::MASK_GAIN_STEP;
        sctr_pkg::ADDR_ARRAY_CAL: osc_array_calibration <= REG_WDATA & sctr_pkg::MASK_ARRAY_CAL;
        sctr_pkg::ADDR_CAL_SETUP: osc_calibration_setup <= REG_WDATA & sctr_pkg::MASK_CAL_SETUP;
        sctr_pkg::ADDR_CURRENT_CAL: osc_current_calibration <= REG_WDATA & sctr_pkg::MASK_CURRENT_CAL;
        sctr_pkg::ADDR_PUMP_CTRL: pump_current_control <= REG_WDATA & sctr_pkg::MASK_PUMP_CTRL;
        default: ;
      endcase
    end
  end

  // Read mux, results merged into read-only fields
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      REG_RDATA <= 16'h0000;
    else
    begin
      case (REG_ADDR)
        sctr_pkg::ADDR_GAIN_STEP: REG_RDATA <= gain_step_difference;
        sctr_pkg::ADDR_ARRAY_CAL: REG_RDATA <= osc_array_calibration | {11'h000, osc_array_result};
        sctr_pkg::ADDR_CAL_SETUP: REG_RDATA <= osc_calibration_setup;
        sctr_pkg::ADDR_CURRENT_CAL: REG_RDATA <= osc_current_calibration | {10'h000, osc_current_result};
        sctr_pkg::ADDR_PUMP_CTRL: REG_RDATA <= pump_current_control;
        default: REG_RDATA <= 16'h0000;
      endcase
    end
  end

  assign MED_TO_HIGH_GAIN_STEP = gain_step_difference[sctr_pkg::MED_HIGH_LSB +: 5];
  assign LOW_TO_MED_GAIN_STEP = gain_step_difference[sctr_pkg::LOW_MED_LSB +: 5];

  // Calibration trigger
  assign cal_start = ENTER_RX | TX_CAL_STROBE
    | (ENTER_TX & !osc_calibration_setup[sctr_pkg::SKIP_TX_CAL_BIT]);

  assign cal_len = osc_calibration_setup[sctr_pkg::MEAS_LONG_BIT] ? 14'(sctr_pkg::CAL_LONG_CYC)
    : 14'(sctr_pkg::CAL_SHORT_CYC);

  always_comb
  begin
    case (pump_current_control[sctr_pkg::STEP_SEL_LSB +: 2])
      2'h0: step_len = 10'(sctr_pkg::STEP_0_CYC);
      2'h1: step_len = 10'(sctr_pkg::STEP_1_CYC);
      2'h2: step_len = 10'(sctr_pkg::STEP_2_CYC);
      default: step_len = 10'(sctr_pkg::STEP_3_CYC);
    endcase
  end

  assign pump_begin = pump_current_control[sctr_pkg::PUMP_BEGIN_LSB +: 4];
  assign pump_end = pump_current_control[sctr_pkg::PUMP_END_LSB +: 4];
  assign step_due = (step_count == step_len - 10'h001);

  // Sequencer: calibrate, then step pump current down
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      state <= sctr_pkg::ST_IDLE;
      cal_count <= 14'h0000;
      step_count <= 10'h000;
      pump_current <= 4'h0;
    end
    else
    begin
      case (state)
        sctr_pkg::ST_IDLE:
        begin
          if (cal_start)
          begin
            state <= sctr_pkg::ST_CAL;
            cal_count <= 14'h0000;
          end
        end
        sctr_pkg::ST_CAL:
        begin
          cal_count <= cal_count + 14'h0001;
          if (cal_count == cal_len - 14'h0001)
          begin
            state <= sctr_pkg::ST_STEP;
            pump_current <= pump_begin;
            step_count <= 10'h000;
          end
        end
        sctr_pkg::ST_STEP:
        begin
          if (cal_start)
          begin
            state <= sctr_pkg::ST_CAL;
            cal_count <= 14'h0000;
          end
          else if (pump_current > pump_end)
          begin
            step_count <= step_due ? 10'h000 : step_count + 10'h001;
            if (step_due)
              pump_current <= pump_current - 4'h1;
          end
        end
        default: state <= sctr_pkg::ST_IDLE;
      endcase
    end
  end

  // Capture calibration results at completion
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      osc_array_result <= 5'h00;
      osc_current_result <= 6'h00;
    end
    else if (state == sctr_pkg::ST_CAL && cal_count == cal_len - 14'h0001)
    begin
      osc_array_result <= CAL_ARRAY_IN;
      osc_current_result <= CAL_CURRENT_IN;
    end
  end

  // Synth control outputs
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      SYNTH <= '0;
      PUMP_UP <= 1'b0;
      PUMP_DOWN <= 1'b0;
      TUNING_FROM_DAC <= 1'b0;
    end
    else
    begin
      SYNTH.osc_array <= osc_array_calibration[sctr_pkg::ARRAY_OE_BIT]
        ? osc_array_calibration[sctr_pkg::ARRAY_O_LSB +: 5] : osc_array_result;
      SYNTH.osc_current_a <= osc_current_calibration[sctr_pkg::CUR_OE_BIT]
        ? osc_current_calibration[sctr_pkg::CUR_O_LSB +: 6] : osc_current_result;
      SYNTH.osc_current_b <= osc_calibration_setup[sctr_pkg::CUR_K_LSB +: 6];
      SYNTH.osc_current_reference <= osc_calibration_setup[sctr_pkg::CUR_REF_LSB +: 4];
      SYNTH.osc_current_cal_speed <= osc_current_calibration[sctr_pkg::CUR_SPEED_LSB +: 2];
      SYNTH.osc_settle_long <= osc_array_calibration[sctr_pkg::SETTLE_LONG_BIT];
      SYNTH.tuning_dac_select <= osc_calibration_setup[sctr_pkg::DAC_SEL_BIT];
      SYNTH.tuning_dac_value <= osc_calibration_setup[sctr_pkg::DAC_VAL_LSB +: 3];
      SYNTH.pump_current <= pump_current_control[sctr_pkg::PUMP_OE_BIT] ? pump_begin : pump_current;
      SYNTH.pump_enable <= !(state == sctr_pkg::ST_CAL
        && pump_current_control[sctr_pkg::PUMP_CAL_OFF_BIT]);
      SYNTH.pump_force_up <= pump_current_control[sctr_pkg::PUMP_UP_BIT];
      SYNTH.pump_force_down <= pump_current_control[sctr_pkg::PUMP_DN_BIT];
      SYNTH.phase_detector_long_delay <= pump_current_control[sctr_pkg::PD_LONG_BIT];
      SYNTH.calibrating <= (state == sctr_pkg::ST_CAL);
      TUNING_FROM_DAC <= !TUNING_TEST_IN && osc_calibration_setup[sctr_pkg::DAC_SEL_BIT];
      PUMP_UP <= pump_current_control[sctr_pkg::PUMP_UP_BIT]
        | (PD_UP & !pump_current_control[sctr_pkg::PUMP_OFF_BIT]);
      PUMP_DOWN <= pump_current_control[sctr_pkg::PUMP_DN_BIT]
        | (PD_DOWN & !pump_current_control[sctr_pkg::PUMP_OFF_BIT]);
    end
  end

  // Cycles spent in the current calibration, for the timing checks
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      cal_age <= 14'h0000;
    else if (state == sctr_pkg::ST_CAL)
      cal_age <= cal_age + 14'h0001;
    else
      cal_age <= 14'h0000;
  end

  // Assertions
  property p_tx_skip;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state != sctr_pkg::ST_CAL && ENTER_TX && !ENTER_RX && !TX_CAL_STROBE
      && osc_calibration_setup[sctr_pkg::SKIP_TX_CAL_BIT]) |=> state != sctr_pkg::ST_CAL;
  endproperty
  a_tx_skip: assert property (p_tx_skip) else $error("tx entry calibrated despite skip");
  property p_array_ovr;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    osc_array_calibration[sctr_pkg::ARRAY_OE_BIT] && $stable(osc_array_calibration)
      |=> SYNTH.osc_array == $past(osc_array_calibration[9:5]);
  endproperty
  a_array_ovr: assert property (p_array_ovr) else $error("array override ignored");
  property p_cur_ovr;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    osc_current_calibration[sctr_pkg::CUR_OE_BIT] |=> SYNTH.osc_current_a == $past(osc_current_calibration[11:6]);
  endproperty
  a_cur_ovr: assert property (p_cur_ovr) else $error("current override ignored");
  property p_pump_cal_off;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_CAL && pump_current_control[15]) |=> !SYNTH.pump_enable;
  endproperty
  a_pump_cal_off: assert property (p_pump_cal_off) else $error("pump on during calibration");
  property p_manual_off;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (pump_current_control[11] && !pump_current_control[13] && !pump_current_control[12]) |=> !PUMP_UP && !PUMP_DOWN;
  endproperty
  a_manual_off: assert property (p_manual_off) else $error("pump pulses not masked");
  property p_force_up;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pump_current_control[13] |=> PUMP_UP;
  endproperty
  a_force_up: assert property (p_force_up) else $error("force up not applied");
  property p_step_floor;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_STEP && $past(state) == sctr_pkg::ST_STEP && $stable(pump_current_control))
      |-> pump_current >= pump_end || pump_current == pump_begin;
  endproperty
  a_step_floor: assert property (p_step_floor) else $error("pump stepped below end");
  property p_step_one;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_STEP && $past(state) == sctr_pkg::ST_STEP && pump_current != $past(pump_current))
      |-> pump_current == $past(pump_current) - 4'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("pump step not one code");
  property p_cal_short;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_CAL && !osc_calibration_setup[sctr_pkg::MEAS_LONG_BIT])
      |-> cal_age < 14'(sctr_pkg::CAL_SHORT_CYC);
  endproperty
  a_cal_short: assert property (p_cal_short) else $error("short calibration too long");
  property p_cal_long;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_CAL && osc_calibration_setup[sctr_pkg::MEAS_LONG_BIT])
      |-> cal_age < 14'(sctr_pkg::CAL_LONG_CYC);
  endproperty
  a_cal_long: assert property (p_cal_long) else $error("long calibration too long");
  property p_cal_min;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_CAL && cal_age < 14'(sctr_pkg::CAL_SHORT_CYC - 1))
      |=> state == sctr_pkg::ST_CAL;
  endproperty
  a_cal_min: assert property (p_cal_min) else $error("calibration ended early");
  property p_rx_cal;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state != sctr_pkg::ST_CAL && ENTER_RX) |=> state == sctr_pkg::ST_CAL;
  endproperty
  a_rx_cal: assert property (p_rx_cal) else $error("receive entry not calibrated");
  property p_pump_begin;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_STEP && $past(state) == sctr_pkg::ST_CAL)
      |-> pump_current == $past(pump_begin);
  endproperty
  a_pump_begin: assert property (p_pump_begin) else $error("pump not started at begin");
  property p_step_hold;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == sctr_pkg::ST_STEP && !cal_start && pump_current <= pump_end)
      |=> pump_current == $past(pump_current);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("pump moved after end");
  property p_pump_ovr;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pump_current_control[sctr_pkg::PUMP_OE_BIT] |=> SYNTH.pump_current == $past(pump_begin);
  endproperty
  a_pump_ovr: assert property (p_pump_ovr) else $error("pump override ignored");
  property p_force_down;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pump_current_control[sctr_pkg::PUMP_DN_BIT] |=> PUMP_DOWN;
  endproperty
  a_force_down: assert property (p_force_down) else $error("force down not applied");
  property p_tuning_test;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    TUNING_TEST_IN |=> !TUNING_FROM_DAC;
  endproperty
  a_tuning_test: assert property (p_tuning_test) else $error("tuning source ignores test input");
  property p_cur_b;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    osc_current_calibration[sctr_pkg::CUR_OE_BIT]
      |=> SYNTH.osc_current_b == $past(osc_calibration_setup[sctr_pkg::CUR_K_LSB +: 6]);
  endproperty
  a_cur_b: assert property (p_cur_b) else $error("current B override wrong");

  // Main scenarios
  c_cal: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    state == sctr_pkg::ST_CAL ##1 state == sctr_pkg::ST_STEP);
  c_step: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    state == sctr_pkg::ST_STEP && step_due);
  c_txcal: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    TX_CAL_STROBE && state != sctr_pkg::ST_CAL);
  c_cal_long: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    osc_calibration_setup[sctr_pkg::MEAS_LONG_BIT] && cal_age == 14'(sctr_pkg::CAL_LONG_CYC - 1));
  c_hold: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    state == sctr_pkg::ST_STEP && pump_current == pump_end && pump_current != pump_begin);
endmodule : sctr_regs

/* pkg/sctr_pkg.sv */
// Package: register map, field layout, reset values and timing for the synth calibration test registers
package sctr_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_GAIN_STEP = 6'h26;
  localparam logic [5:0] ADDR_ARRAY_CAL = 6'h27;
  localparam logic [5:0] ADDR_CAL_SETUP = 6'h28;
  localparam logic [5:0] ADDR_CURRENT_CAL = 6'h29;
  localparam logic [5:0] ADDR_PUMP_CTRL = 6'h2A;
  // Writable masks; reserved and read-only bits are dropped
  localparam logic [15:0] MASK_GAIN_STEP = 16'h03FF;
  localparam logic [15:0] MASK_ARRAY_CAL = 16'h0FE0;
  localparam logic [15:0] MASK_CAL_SETUP = 16'hFFFF;
  localparam logic [15:0] MASK_CURRENT_CAL = 16'h7FC0;
  localparam logic [15:0] MASK_PUMP_CTRL = 16'hFFFF;
  // Reset values
  localparam logic [15:0] RST_GAIN_STEP = 16'h012A;
  localparam logic [15:0] RST_ARRAY_CAL = 16'h0200;
  localparam logic [15:0] RST_CAL_SETUP = 16'h5002;
  localparam logic [15:0] RST_CURRENT_CAL = 16'h0600;
  localparam logic [15:0] RST_PUMP_CTRL = 16'h82DD;
  // Field positions
  localparam int MED_HIGH_LSB = 5;
  localparam int LOW_MED_LSB = 0;
  localparam int SETTLE_LONG_BIT = 11;
  localparam int ARRAY_OE_BIT = 10;
  localparam int ARRAY_O_LSB = 5;
  localparam int SKIP_TX_CAL_BIT = 15;
  localparam int MEAS_LONG_BIT = 14;
  localparam int CUR_REF_LSB = 10;
  localparam int CUR_K_LSB = 4;
  localparam int DAC_SEL_BIT = 3;
  localparam int DAC_VAL_LSB = 0;
  localparam int CUR_SPEED_LSB = 13;
  localparam int CUR_OE_BIT = 12;
  localparam int CUR_O_LSB = 6;
  localparam int PUMP_CAL_OFF_BIT = 15;
  localparam int PUMP_OE_BIT = 14;
  localparam int PUMP_UP_BIT = 13;
  localparam int PUMP_DN_BIT = 12;
  localparam int PUMP_OFF_BIT = 11;
  localparam int PD_LONG_BIT = 10;
  localparam int STEP_SEL_LSB = 8;
  localparam int PUMP_END_LSB = 4;
  localparam int PUMP_BEGIN_LSB = 0;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CAL_SHORT_US = 37;
  localparam int CAL_LONG_US = 57;
  localparam int CAL_SHORT_CYC = CAL_SHORT_US * CLK_MHZ;
  localparam int CAL_LONG_CYC = CAL_LONG_US * CLK_MHZ;
  localparam int STEP_0_NS = 250;
  localparam int STEP_1_NS = 500;
  localparam int STEP_2_NS = 1000;
  localparam int STEP_3_NS = 4000;
  localparam int STEP_0_CYC = STEP_0_NS * CLK_MHZ / 1000;
  localparam int STEP_1_CYC = STEP_1_NS * CLK_MHZ / 1000;
  localparam int STEP_2_CYC = STEP_2_NS * CLK_MHZ / 1000;
  localparam int STEP_3_CYC = STEP_3_NS * CLK_MHZ / 1000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAL = 3'b010,
    ST_STEP = 3'b100
  } sctr_state_t;
  // Analog synthesizer controls
  typedef struct packed {
    logic [4:0] osc_array;
    logic [5:0] osc_current_a;
    logic [5:0] osc_current_b;
    logic [3:0] osc_current_reference;
    logic [1:0] osc_current_cal_speed;
    logic osc_settle_long;
    logic tuning_dac_select;
    logic [2:0] tuning_dac_value;
    logic [3:0] pump_current;
    logic pump_enable;
    logic pump_force_up;
    logic pump_force_down;
    logic phase_detector_long_delay;
    logic calibrating;
  } sctr_synth_t;
endpackage : sctr_pkg

/* verification/sctr_host.sv */
// Host model: writes and reads the bank on the configuration port
module sctr_host (
  input wire logic SYS_CLK, // Clock
  input wire logic [15:0] REG_RDATA, // Read data
  output logic REG_WR, // Write strobe
  output logic [5:0] REG_ADDR, // Address
  output logic [15:0] REG_WDATA // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    REG_WR = 1'b0;
    REG_ADDR = 6'h00;
    REG_WDATA = 16'h0000;
  end
  task automatic write(input logic [5:0] a, input logic [15:0] d, input logic [15:0] m);
    @(negedge SYS_CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d & m;
    @(negedge SYS_CLK);
    REG_WR = 1'b0;
    REG_WDATA = ~REG_WDATA;
  endtask : write
  task automatic read(input logic [5:0] a, output logic [15:0] q);
    @(negedge SYS_CLK);
    REG_ADDR = a;
    @(negedge SYS_CLK);
    q = REG_RDATA;
  endtask : read
endmodule : sctr_host

/* verification/sctr_regs_bench.sv */
// Bench for the synth calibration test registers
module sctr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic REG_WR;
  logic [5:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, q, obs;
  logic [2:0] trg = 3'h0;
  logic [1:0] pd = 2'h0;
  logic tin = 1'b0;
  logic [4:0] cal_a = 5'h00;
  logic [5:0] cal_c = 6'h00;
  logic [4:0] med, low;
  logic up, dn, dac, pe;
  sctr_pkg::sctr_synth_t syn;
  logic [15:0] rv [5] = '{16'h012A, 16'h0200, 16'h5002, 16'h0600, 16'h82DD};
  logic [15:0] wm [5] = '{16'h03FF, 16'h0FE0, 16'hFFFF, 16'h7FC0, 16'hFFFF};
  logic [15:0] w [5];
  logic [15:0] exp_q [$];
  event obs_ev;
  int failures = 0;
  int check_count = 0;
  int seed = 29;
  int n;
  always #2.5 SYS_CLK = ~SYS_CLK;
  sctr_host u_host (.SYS_CLK(SYS_CLK), .REG_RDATA(REG_RDATA), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA));
  sctr_regs u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ENTER_RX(trg[0]), .ENTER_TX(trg[1]),
    .TX_CAL_STROBE(trg[2]), .CAL_ARRAY_IN(cal_a), .CAL_CURRENT_IN(cal_c), .PD_UP(pd[1]), .PD_DOWN(pd[0]),
    .TUNING_TEST_IN(tin), .MED_TO_HIGH_GAIN_STEP(med), .LOW_TO_MED_GAIN_STEP(low), .PUMP_UP(up),
    .PUMP_DOWN(dn), .TUNING_FROM_DAC(dac), .SYNTH(syn));
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    obs = g;
    ->obs_ev;
    #1;
  endtask : chk
  always @(obs_ev)
  begin : watch
    logic [15:0] e;
    e = exp_q.pop_front();
    check_count++;
    if (obs !== e)
    begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, obs);
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge SYS_CLK);
  endtask : cyc
  task automatic pulse(input int i);
    @(negedge SYS_CLK);
    trg[i] = 1'b1;
    @(negedge SYS_CLK);
    trg = 3'h0;
  endtask : pulse
  // Counts cycles of calibration, samples pump enable partway
  task automatic cal_run(output int c, output logic p);
    c = 0;
    p = 1'b1;
    for (int k = 0; k < 10 && syn.calibrating !== 1'b1; k++) cyc(1);
    while (syn.calibrating === 1'b1 && c < 20000)
    begin
      c++;
      if (c == 100) p = syn.pump_enable;
      cyc(1);
    end
  endtask : cal_run
  task automatic stop_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #400us;
    failures++;
    stop_test();
  end
  initial
  begin
    cal_a = 5'($random(seed));
    cal_c = 6'($random(seed));
    cyc(4);
    RESET_N = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      u_host.read(6'(6'h26 + i), q);
      chk(rv[i], q);
    end
    chk(16'h012A, {6'h00, med, low});
    u_host.read(6'h2B, q);
    chk(16'h0000, q);
    $display("end: reset");
    for (int i = 0; i < 5; i++)
    begin
      w[i] = 16'($random(seed)) & wm[i];
      // Speed code 3 is not to be used
      if (i == 3 && w[i][14:13] == 2'h3)
        w[i][13] = 1'b0;
      u_host.write(6'(6'h26 + i), w[i], wm[i]);
      u_host.read(6'(6'h26 + i), q);
      chk(w[i], q);
    end
    chk({1'b0, w[0][9:0], w[2][3:0], 1'b0},
      {1'b0, med, low, dac, syn.tuning_dac_value, 1'b0});
    chk({w[2][13:10], w[3][14:13], w[1][11], w[4][10], 8'h00}, {syn.osc_current_reference, syn.osc_current_cal_speed,
      syn.osc_settle_long, syn.phase_detector_long_delay, 8'h00});
    cyc(1);
    tin = 1'b1;
    cyc(2);
    tin = 1'b0;
    chk({14'h0000, w[2][3], 1'b0}, {14'h0000, syn.tuning_dac_select, dac});
    $display("end: random access");
    u_host.write(6'h27, 16'h0560, wm[1]);
    u_host.write(6'h29, 16'h1540, wm[3]);
    u_host.write(6'h28, 16'h02A0, wm[2]);
    u_host.write(6'h2A, 16'h40C3, wm[4]);
    cyc(2);
    chk({5'h0B, 6'h15, 4'h3, 1'b0}, {syn.osc_array, syn.osc_current_a, syn.pump_current, 1'b0});
    chk(16'h002A, {10'h000, syn.osc_current_b});
    u_host.write(6'h2A, 16'h2800, wm[4]);
    pd = 2'b11;
    cyc(2);
    chk(16'h000A, {12'h000, up, dn, syn.pump_force_up, syn.pump_force_down});
    u_host.write(6'h2A, 16'h1000, wm[4]);
    pd = 2'b10;
    cyc(2);
    chk(16'h000D, {12'h000, up, dn, syn.pump_force_up, syn.pump_force_down});
    pd = 2'b00;
    $display("end: overrides");
    u_host.write(6'h27, 16'h0000, wm[1]);
    u_host.write(6'h29, 16'h0000, wm[3]);
    u_host.write(6'h2A, 16'h8025, wm[4]);
    pulse(0);
    cal_run(n, pe);
    chk(16'h1CE8, 16'(n));
    chk(16'h0000, {15'h0000, pe});
    cyc(5);
    chk(16'h0005, {12'h000, syn.pump_current});
    cyc(50);
    chk(16'h0004, {12'h000, syn.pump_current});
    cyc(200);
    chk(16'h0002, {12'h000, syn.pump_current});
    u_host.read(6'h27, q);
    chk({11'h000, cal_a}, q);
    u_host.read(6'h29, q);
    chk({10'h000, cal_c}, q);
    chk({11'h000, cal_a}, {11'h000, syn.osc_array});
    $display("end: receive calibration");
    u_host.write(6'h28, 16'hC000, wm[2]);
    pulse(1);
    cyc(20);
    chk(16'h0000, {15'h0000, syn.calibrating});
    pulse(2);
    cal_run(n, pe);
    chk(16'h2C88, 16'(n));
    u_host.write(6'h28, 16'h0000, wm[2]);
    pulse(1);
    cal_run(n, pe);
    chk(16'h1CE8, 16'(n));
    $display("end: transmit calibration");
    stop_test();
  end
endmodule : sctr_regs_bench
